// File: logic/ppsl_status_core.sv
// process-data framing, run command decode and status word of the positioner
// Overview of operation
// - receive frame identifier is 200h plus node
// - bytes 0,1 control word, bytes 2,3 ignored
// - bytes 4-7 carry 32-bit target position
// - transmit frame identifier is 180h plus node
// - transmit status, speed, actual position in order
// - bit 0 set on reaching target
// - bit 0 cleared by far target, manual, invalid
// - bit 1 drag error, cleared by run command
// - bits 2,3 follow reverse and forward keys
// - bit 4 supply inside lower limit and 30V
// - bit 5 release withdrawn positioning abort, cleared next run
// - bit 6 follows drive rotating
// - bit 7 overtemperature with 5 degree hysteresis
// - bit 8 motion against loop direction
// - bit 9 calculation error, cleared by reference loop
// - error refuses all but reference loop
// - bit 10 block abort, cleared by new positioning
// - bit 11 external displacement at standstill
// - bit 12 invalid target, cleared by valid
// - bit 13 supply outside corridor at start/run
// - bits 14,15 range limits outside positioning runs
// - range limit bits cleared on any run start
// - runs need release; withdrawal aborts, sets bit 5 in positioning runs only
// - frame target starts only with transfer bit
module ppsl_status_core
  import ppsl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [6:0] nodeAddrPin,
  input wire logic jogRevKeyPin,
  input wire logic jogFwdKeyPin,
  input wire logic rxValid,
  input wire logic [10:0] rxId,
  input wire logic [63:0] rxData,
  output logic txValid,
  input wire logic txReady,
  output logic [10:0] txId,
  output logic [63:0] txData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regIndex,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  output logic regAck,
  output logic regErr,
  input wire logic [31:0] actualPosition,
  input wire logic [15:0] currentSpeed,
  input wire logic [15:0] motorMillivolt,
  input wire logic [7:0] temperatureC,
  input wire logic mcRotating,
  input wire logic mcAgainstLoop,
  input wire logic mcTargetReached,
  input wire logic mcRefLoopDone,
  input wire logic mcRefLoopOk,
  input wire logic mcRunDone,
  input wire logic mcAccelShort,
  input wire logic mcCalcFault,
  input wire logic mcBlockAbort,
  input wire logic mcDisplaced,
  input wire logic mcTargetValid,
  input wire logic mcTargetInvalid,
  input wire logic mcPosLimitHit,
  input wire logic mcNegLimitHit,
  output logic cmdStartPosition,
  output logic cmdStartManual,
  output logic cmdManualUp,
  output logic cmdStartRefLoop,
  output logic cmdAbort,
  output logic [31:0] cmdTarget,
  output logic [15:0] cmdControl
);

  // pin capture
  logic [6:0] nodeAddr;
  logic jogRev;
  logic jogFwd;

  ppsl_pin_sync #(
    .WIDTH(9)
  ) uPinSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn({jogRevKeyPin, jogFwdKeyPin, nodeAddrPin}),
    .syncOut({jogRev, jogFwd, nodeAddr})
  );

  // receive frame decode
  logic rxHit;
  logic [15:0] pdoControl;
  logic [31:0] pdoTarget;

  assign rxHit = rxValid && (nodeAddr != 7'h00) && (rxId == (RPDO_ID_BASE + {4'h0, nodeAddr}));
  assign pdoControl = rxData[CW_LSB +: 16];
  assign pdoTarget = rxData[POS_LSB +: 32];

  // parameter and control state
  logic [15:0] control_r, control_nxt;
  logic [31:0] target_r, target_nxt;
  logic [31:0] window_r, window_nxt;
  logic [15:0] voltLimit_r, voltLimit_nxt;
  logic [7:0] tempLimit_r, tempLimit_nxt;
  logic targetPend_r, targetPend_nxt;
  ppsl_run_e runMode_r, runMode_nxt;
  // status is read by the register port and gates run starts, so it is declared here
  logic [15:0] status_r, status_nxt;
  logic xferEvt;
  logic posStart, manStart, refStart, abortEvt, manStop, anyStart;
  logic relOld, relNew, manReqOld, manReqNew, refReqOld, refReqNew;
  logic [31:0] regRdData_nxt;
  logic regErr_nxt;

  always_comb begin
    control_nxt = control_r;
    target_nxt = target_r;
    window_nxt = window_r;
    voltLimit_nxt = voltLimit_r;
    tempLimit_nxt = tempLimit_r;
    xferEvt = 1'b0;
    regErr_nxt = 1'b0;
    regRdData_nxt = 32'h0000_0000;
    if (regWrite) begin
      unique case (regIndex)
        IDX_TARGET: begin
          target_nxt = regWrData;
          xferEvt = 1'b1;
        end
        IDX_CONTROL: control_nxt = regWrData[15:0];
        IDX_WINDOW: window_nxt = regWrData;
        IDX_VOLT_LIMIT: voltLimit_nxt = regWrData[15:0];
        IDX_TEMP_LIMIT: tempLimit_nxt = regWrData[7:0];
        default: regErr_nxt = 1'b1;
      endcase
    end else if (regRead) begin
      unique case (regIndex)
        IDX_TARGET: regRdData_nxt = target_r;
        IDX_ACTUAL: regRdData_nxt = actualPosition;
        IDX_WINDOW: regRdData_nxt = window_r;
        IDX_CONTROL: regRdData_nxt = {16'h0000, control_r};
        IDX_STATUS: regRdData_nxt = {16'h0000, status_r};
        IDX_SPEED: regRdData_nxt = {16'h0000, currentSpeed};
        IDX_VOLT_LIMIT: regRdData_nxt = {16'h0000, voltLimit_r};
        IDX_TEMP_LIMIT: regRdData_nxt = {24'h000000, tempLimit_r};
        default: regErr_nxt = 1'b1;
      endcase
    end
    // a frame arriving with a register write overrides the same fields
    if (rxHit) begin
      control_nxt = pdoControl;
      target_nxt = pdoTarget;
      xferEvt = pdoControl[CW_XFER];
    end
  end

  // run command decode
  always_comb begin
    relOld = control_r[CW_RELEASE];
    relNew = control_nxt[CW_RELEASE];
    manReqOld = relOld && (control_r[CW_MAN_UP] || control_r[CW_MAN_DOWN]);
    manReqNew = relNew && (control_nxt[CW_MAN_UP] || control_nxt[CW_MAN_DOWN]);
    refReqOld = relOld && control_r[CW_REF_LOOP];
    refReqNew = relNew && control_nxt[CW_REF_LOOP];
    // reference loop is the only run allowed while the error flag stands
    refStart = refReqNew && !refReqOld;
    posStart = !refStart && relNew && !status_r[ST_ERROR] &&
               (xferEvt || (!relOld && targetPend_r));
    manStart = !refStart && !posStart && manReqNew && !manReqOld && !status_r[ST_ERROR];
    anyStart = refStart || posStart || manStart;
    // release falling mid-run stops whatever kind of run is active
    abortEvt = relOld && !relNew && (runMode_r != RUN_IDLE);
    manStop = (runMode_r == RUN_MANUAL) && relNew && !manReqNew && !anyStart;
    targetPend_nxt = targetPend_r;
    if (xferEvt && !relNew) begin
      targetPend_nxt = 1'b1;
    end else if (posStart || refStart) begin
      targetPend_nxt = 1'b0;
    end
    runMode_nxt = runMode_r;
    unique case (runMode_r)
      RUN_IDLE, RUN_POSITION, RUN_MANUAL, RUN_REF_LOOP: begin
        if (refStart) begin
          runMode_nxt = RUN_REF_LOOP;
        end else if (posStart) begin
          runMode_nxt = RUN_POSITION;
        end else if (manStart) begin
          runMode_nxt = RUN_MANUAL;
        end else if (abortEvt || manStop || mcRunDone || mcBlockAbort) begin
          runMode_nxt = RUN_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control_r <= CONTROL_RESET;
      target_r <= 32'h0000_0000;
      window_r <= WINDOW_RESET;
      voltLimit_r <= VOLT_LIMIT_RESET;
      tempLimit_r <= TEMP_LIMIT_RESET;
      targetPend_r <= 1'b0;
      runMode_r <= RUN_IDLE;
      regRdData <= 32'h0000_0000;
      regAck <= 1'b0;
      regErr <= 1'b0;
      cmdStartPosition <= 1'b0;
      cmdStartManual <= 1'b0;
      cmdManualUp <= 1'b0;
      cmdStartRefLoop <= 1'b0;
      cmdAbort <= 1'b0;
    end else begin
      control_r <= control_nxt;
      target_r <= target_nxt;
      window_r <= window_nxt;
      voltLimit_r <= voltLimit_nxt;
      tempLimit_r <= tempLimit_nxt;
      targetPend_r <= targetPend_nxt;
      runMode_r <= runMode_nxt;
      regRdData <= regRdData_nxt;
      regAck <= regWrite || regRead;
      regErr <= regErr_nxt;
      cmdStartPosition <= posStart;
      cmdStartManual <= manStart;
      cmdManualUp <= manStart ? control_nxt[CW_MAN_UP] : cmdManualUp;
      cmdStartRefLoop <= refStart;
      cmdAbort <= abortEvt || manStop;
    end
  end

  assign cmdTarget = target_r;
  assign cmdControl = control_r;

  // status word
  logic [15:0] stSet, stClr;
  logic inCorridor;
  logic [32:0] posDiff;
  logic [32:0] posDist;
  logic farTarget;
  logic tempHigh, tempLow;
  logic limitAllowed;

  always_comb begin
    inCorridor = (motorMillivolt > voltLimit_r) && (motorMillivolt < MOTOR_MAX_MV);
    // signed distance one bit wider, so targets far apart cannot wrap
    posDiff = 33'($signed({target_nxt[31], target_nxt}) - $signed({actualPosition[31], actualPosition}));
    posDist = posDiff[32] ? 33'(-posDiff) : posDiff;
    farTarget = posDist > {1'b0, window_r};
    tempHigh = temperatureC > tempLimit_r;
    tempLow = ({1'b0, temperatureC} + TEMP_HYST_C) < {1'b0, tempLimit_r};
    limitAllowed = (runMode_r != RUN_POSITION);
    stSet = 16'h0000;
    stClr = 16'h0000;
    // set terms
    stSet[ST_REACHED] = mcTargetReached ||
                        (mcRefLoopDone && mcRefLoopOk && (actualPosition == target_r));
    stSet[ST_DRAG] = mcAccelShort;
    stSet[ST_ABORTED] = abortEvt && (runMode_r == RUN_POSITION);
    stSet[ST_OVERTEMP] = tempHigh;
    stSet[ST_AGAINST_LOOP] = mcAgainstLoop && (runMode_r != RUN_IDLE);
    stSet[ST_ERROR] = mcCalcFault;
    stSet[ST_BLOCKED] = mcBlockAbort;
    stSet[ST_DISPLACED] = mcDisplaced && !mcRotating;
    stSet[ST_BAD_TARGET] = mcTargetInvalid;
    stSet[ST_POWER_MISSED] = ((posStart || refStart) && !inCorridor) ||
                             ((runMode_r != RUN_IDLE) && !inCorridor);
    stSet[ST_POS_LIMIT] = mcPosLimitHit && limitAllowed;
    stSet[ST_NEG_LIMIT] = mcNegLimitHit && limitAllowed;
    // clear terms
    stClr[ST_REACHED] = (xferEvt && farTarget) || manStart || mcTargetInvalid || mcDisplaced;
    stClr[ST_DRAG] = anyStart;
    stClr[ST_ABORTED] = anyStart;
    stClr[ST_OVERTEMP] = tempLow;
    stClr[ST_AGAINST_LOOP] = (mcTargetReached && !mcAgainstLoop) || mcRefLoopDone;
    stClr[ST_ERROR] = mcRefLoopDone && mcRefLoopOk;
    stClr[ST_BLOCKED] = posStart || (mcRefLoopDone && mcRefLoopOk);
    stClr[ST_DISPLACED] = posStart || (mcRefLoopDone && mcRefLoopOk);
    stClr[ST_BAD_TARGET] = mcTargetValid;
    stClr[ST_POWER_MISSED] = (posStart || refStart) && inCorridor;
    stClr[ST_POS_LIMIT] = anyStart;
    stClr[ST_NEG_LIMIT] = anyStart;
    // an event in the clearing cycle wins
    status_nxt = (status_r & ~stClr) | stSet;
    status_nxt[ST_JOG_REV] = jogRev;
    status_nxt[ST_JOG_FWD] = jogFwd;
    status_nxt[ST_POWER_OK] = inCorridor;
    status_nxt[ST_RUNNING] = mcRotating;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_r <= STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // transmit frame on every status change while the node address is not 0
  logic txPend_r, txPend_nxt;
  logic txValid_r, txValid_nxt;
  logic [63:0] txData_r, txData_nxt;
  logic [10:0] txId_r, txId_nxt;
  logic txLaunch;

  always_comb begin
    // node 0 sends nothing; the pending flag waits for a valid address
    // changes during an outstanding frame fold into the next one
    txLaunch = !txValid_r && txPend_r && (nodeAddr != 7'h00);
    txPend_nxt = (txPend_r && !txLaunch) || (status_nxt != status_r);
    txValid_nxt = txValid_r;
    txData_nxt = txData_r;
    txId_nxt = txId_r;
    if (txValid_r && txReady) begin
      txValid_nxt = 1'b0;
    end else if (txLaunch) begin
      // frame content is frozen here and held until accepted
      txValid_nxt = 1'b1;
      txId_nxt = TPDO_ID_BASE + {4'h0, nodeAddr};
      txData_nxt = {actualPosition, currentSpeed, status_r};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txPend_r <= 1'b0;
      txValid_r <= 1'b0;
      txData_r <= 64'h0000_0000_0000_0000;
      txId_r <= 11'h000;
    end else begin
      txPend_r <= txPend_nxt;
      txValid_r <= txValid_nxt;
      txData_r <= txData_nxt;
      txId_r <= txId_nxt;
    end
  end

  assign txValid = txValid_r;
  assign txData = txData_r;
  assign txId = txId_r;

endmodule : ppsl_status_core

// File: logic/ppsl_pkg.sv
// constants shared by the positioner process-data and status-word logic
package ppsl_pkg;

  // process-data frame identifiers, node address is added
  localparam logic [10:0] RPDO_ID_BASE = 11'h200;
  localparam logic [10:0] TPDO_ID_BASE = 11'h180;

  // parameter indices reachable through the register port
  localparam logic [15:0] IDX_TARGET = 16'h2001;
  localparam logic [15:0] IDX_ACTUAL = 16'h2003;
  localparam logic [15:0] IDX_WINDOW = 16'h2006;
  localparam logic [15:0] IDX_CONTROL = 16'h2024;
  localparam logic [15:0] IDX_STATUS = 16'h2025;
  localparam logic [15:0] IDX_SPEED = 16'h2030;
  localparam logic [15:0] IDX_VOLT_LIMIT = 16'h203C;
  localparam logic [15:0] IDX_TEMP_LIMIT = 16'h203E;

  // frame byte layout as bit positions (little-endian bytes)
  localparam int CW_LSB = 0;
  localparam int SPEED_LSB = 16;
  localparam int POS_LSB = 32;

  // control word bits
  localparam int CW_MAN_UP = 0;
  localparam int CW_MAN_DOWN = 1;
  localparam int CW_XFER = 2;
  localparam int CW_RELEASE = 4;
  localparam int CW_REF_LOOP = 7;

  // status word bits
  localparam int ST_REACHED = 0;
  localparam int ST_DRAG = 1;
  localparam int ST_JOG_REV = 2;
  localparam int ST_JOG_FWD = 3;
  localparam int ST_POWER_OK = 4;
  localparam int ST_ABORTED = 5;
  localparam int ST_RUNNING = 6;
  localparam int ST_OVERTEMP = 7;
  localparam int ST_AGAINST_LOOP = 8;
  localparam int ST_ERROR = 9;
  localparam int ST_BLOCKED = 10;
  localparam int ST_DISPLACED = 11;
  localparam int ST_BAD_TARGET = 12;
  localparam int ST_POWER_MISSED = 13;
  localparam int ST_POS_LIMIT = 14;
  localparam int ST_NEG_LIMIT = 15;

  // supply corridor upper bound and temperature hysteresis
  localparam int MOTOR_MAX_V = 30;
  localparam logic [15:0] MOTOR_MAX_MV = 16'(MOTOR_MAX_V * 1000);
  localparam logic [8:0] TEMP_HYST_C = 9'h005;

  // reset values of the writable parameters and of the read-only status word
  localparam logic [31:0] WINDOW_RESET = 32'h0000_000A;
  localparam logic [15:0] VOLT_LIMIT_RESET = 16'h4650;
  localparam logic [7:0] TEMP_LIMIT_RESET = 8'h50;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  typedef enum logic [1:0] {
    RUN_IDLE,
    RUN_POSITION,
    RUN_MANUAL,
    RUN_REF_LOOP
  } ppsl_run_e;

endpackage : ppsl_pkg

// File: logic/ppsl_pin_sync.sv
// two-stage synchroniser for asynchronous pin inputs
module ppsl_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : gBit
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          stage1_r[i] <= 1'b0;
          stage2_r[i] <= 1'b0;
        end else begin
          stage1_r[i] <= pinIn[i];
          stage2_r[i] <= stage1_r[i];
        end
      end
    end
  endgenerate

  assign syncOut = stage2_r;

endmodule : ppsl_pin_sync

// File: test/ppsl_status_monitor.sv
// concurrent checks on the positioner status core ports
module ppsl_status_monitor
  import ppsl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [6:0] nodeAddrPin,
  input wire logic jogRevKeyPin,
  input wire logic jogFwdKeyPin,
  input wire logic rxValid,
  input wire logic [10:0] rxId,
  input wire logic [63:0] rxData,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [10:0] txId,
  input wire logic [63:0] txData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regIndex,
  input wire logic [31:0] regRdData,
  input wire logic regAck,
  input wire logic regErr,
  input wire logic mcBlockAbort,
  input wire logic cmdStartPosition,
  input wire logic cmdStartManual,
  input wire logic cmdStartRefLoop,
  input wire logic [31:0] cmdTarget,
  input wire logic [15:0] cmdControl
);
  // cycles since reset release, saturating, so synchronisers have flushed
  logic [2:0] quiet_r, quiet_nxt;
  always_comb begin
    quiet_nxt = quiet_r;
    if (rst) begin
      quiet_nxt = 3'h0;
    end else if (quiet_r != 3'h7) begin
      quiet_nxt = quiet_r + 3'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    quiet_r <= quiet_nxt;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_rx_copy;
    logic [63:0] d;
    (rxValid && nodeAddrPin != 7'h00 && rxId == RPDO_ID_BASE + 11'(nodeAddrPin) && quiet_r == 3'h7, d = rxData)
      |=> cmdControl == d[15:0] && cmdTarget == d[63:32];
  endproperty
  a_rx_copy: assert property (p_rx_copy)
    else $error("received frame not copied");
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txId))
    else $error("frame changed while stalled");
  a_tx_free: assert property (txValid && txReady |=> !txValid)
    else $error("frame kept after acceptance");
  a_tx_ident: assert property (txValid && quiet_r == 3'h7 |-> txId == TPDO_ID_BASE + 11'(nodeAddrPin))
    else $error("transmit identifier wrong");
  a_ro_refuse: assert property (regWrite && (regIndex == IDX_STATUS || regIndex == IDX_ACTUAL ||
    regIndex == IDX_SPEED) |=> regAck && regErr)
    else $error("read-only write accepted");
  a_key_follow: assert property (regRead && !regWrite && regIndex == IDX_STATUS && quiet_r == 3'h7 &&
    jogRevKeyPin == $past(jogRevKeyPin, 4) && jogFwdKeyPin == $past(jogFwdKeyPin, 4)
    |=> regRdData[3:2] == {$past(jogFwdKeyPin), $past(jogRevKeyPin)})
    else $error("key flags wrong");
  a_block_report: assert property (mcBlockAbort |-> ##2 ($rose(txValid) |-> txData[ST_BLOCKED]))
    else $error("block flag missing in frame");
  a_idle_start: assert property (rxValid && rxId == RPDO_ID_BASE + 11'(nodeAddrPin) && rxData[15:0] == 16'h0000 &&
    !$past(rxValid) && !$past(regWrite) |-> ##1 !(cmdStartPosition || cmdStartManual || cmdStartRefLoop))
    else $error("run started without release");
  c_start: cover property (cmdStartPosition);
  c_stall: cover property (txValid && !txReady ##1 txValid && txReady);
  c_refused: cover property (regAck && regErr);
endmodule : ppsl_status_monitor

bind ppsl_status_core ppsl_status_monitor u_mon (.sys_clk, .rst, .nodeAddrPin, .jogRevKeyPin, .jogFwdKeyPin,
  .rxValid, .rxId, .rxData, .txValid, .txReady, .txId, .txData, .regWrite, .regRead, .regIndex, .regRdData,
  .regAck, .regErr, .mcBlockAbort, .cmdStartPosition, .cmdStartManual, .cmdStartRefLoop, .cmdTarget, .cmdControl);

// File: test/ppsl_can_master.sv
// behavioural bus master: sends control frames, takes status frames
module ppsl_can_master (
  input wire logic sys_clk,
  output logic rxValid,
  output logic [10:0] rxId,
  output logic [63:0] rxData,
  input wire logic txValid,
  input wire logic [10:0] txId,
  input wire logic [63:0] txData,
  output logic txReady
);
  timeunit 1ns;
  timeprecision 1ns;
  int stall = 0;
  int waited = 0;
  int frames = 0;
  logic [10:0] lastId = 11'h000;
  logic [63:0] lastData = 64'h0;
  initial begin
    rxValid = 1'b0;
    rxId = 11'h000;
    rxData = 64'h0;
    txReady = 1'b1;
  end
  task automatic send(input logic [15:0] ctrl, input logic [31:0] target, input logic [6:0] node);
    @(negedge sys_clk);
    rxId = 11'h200 + 11'(node);
    rxData = {target, 16'hA5C3, ctrl};
    rxValid = 1'b1;
    @(negedge sys_clk);
    rxValid = 1'b0;
    rxId = ~rxId;
    rxData = ~rxData;
  endtask : send
  always @(posedge sys_clk) begin
    if (txValid === 1'b1 && txReady) begin
      frames <= frames + 1;
      lastId <= txId;
      lastData <= txData;
    end
  end
  // stall mode: accept only after the frame has waited the set cycles
  always @(negedge sys_clk) begin
    waited = (txValid === 1'b1) ? waited + 1 : 0;
    txReady = (stall == 0) || (waited > stall);
  end
endmodule : ppsl_can_master

// File: test/testbench.sv
// self-checking bench for the positioner status core
module testbench
  import ppsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst = 1'b1, jogRevKeyPin = 1'b0, jogFwdKeyPin = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [6:0] nodeAddrPin = 7'h01;
  logic [13:0] mc = 14'h0000;
  logic [15:0] regIndex = 16'h0000, currentSpeed = 16'h0000, motorMillivolt = 16'h0000, cmdControl;
  logic [31:0] regWrData = 32'h0, actualPosition = 32'h0, regRdData, cmdTarget;
  logic [7:0] temperatureC = 8'h00;
  logic rxValid, txValid, txReady, regAck, regErr, cmdStartPosition, cmdStartManual, cmdStartRefLoop, cmdAbort;
  logic [10:0] rxId, txId;
  logic [63:0] rxData, txData;
  int num_errors = 0, tests_run = 0, nPos = 0, nRef = 0, nAb = 0, fMark = 0;
  always #25 sys_clk = ~sys_clk;
  ppsl_status_core DUT (.sys_clk, .rst, .nodeAddrPin, .jogRevKeyPin, .jogFwdKeyPin, .rxValid, .rxId, .rxData,
    .txValid, .txReady, .txId, .txData, .regWrite, .regRead, .regIndex, .regWrData, .regRdData, .regAck, .regErr,
    .actualPosition, .currentSpeed, .motorMillivolt, .temperatureC, .mcRotating(mc[0]), .mcAgainstLoop(mc[1]),
    .mcTargetReached(mc[2]), .mcRefLoopDone(mc[3]), .mcRefLoopOk(mc[4]), .mcRunDone(mc[5]), .mcAccelShort(mc[6]),
    .mcCalcFault(mc[7]), .mcBlockAbort(mc[8]), .mcDisplaced(mc[9]), .mcTargetValid(mc[10]),
    .mcTargetInvalid(mc[11]), .mcPosLimitHit(mc[12]), .mcNegLimitHit(mc[13]), .cmdStartPosition,
    .cmdStartManual, .cmdManualUp(), .cmdStartRefLoop, .cmdAbort, .cmdTarget, .cmdControl);
  ppsl_can_master m (.sys_clk, .rxValid, .rxId, .rxData, .txValid, .txId, .txData, .txReady);
  always @(posedge sys_clk) begin
    nPos += int'(cmdStartPosition === 1'b1);
    nRef += int'(cmdStartRefLoop === 1'b1);
    nAb += int'(cmdAbort === 1'b1);
  end
  task automatic stop_test;
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic tick(input int n = 1);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [31:0] d, output logic [31:0] rd,
    output logic er);
    regWrite = wr;
    regRead = !wr;
    regIndex = idx;
    regWrData = d;
    tick();
    chk(regAck, 1'b1, "no ack");
    rd = regRdData;
    er = regErr;
    regWrite = 1'b0;
    regRead = 1'b0;
    tick();
  endtask : acc
  // bounded settle, then a frame since the last judgement must exist and the newest is judged
  task automatic frame(input logic [15:0] mask, input logic [15:0] st);
    tick(14);
    chk(m.frames > fMark, 1'b1, "no frame");
    fMark = m.frames;
    chk(m.lastId, 11'h181, "tx id");
    chk(m.lastData[15:0] & mask, st, "status");
  endtask : frame
  task automatic mcp(input logic [13:0] p);
    mc = p;
    tick();
    mc = 14'h0000;
  endtask : mcp
  task automatic s_regs;
    logic [15:0] idx [4] = '{IDX_WINDOW, IDX_VOLT_LIMIT, IDX_TEMP_LIMIT, IDX_STATUS};
    logic [31:0] ex [4] = '{32'h0000_000A, 32'h0000_4650, 32'h0000_0050, 32'h0};
    logic [31:0] rd;
    logic er;
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, idx[i], 32'h0, rd, er);
      chk(rd, ex[i], "reset value");
    end
    acc(1'b1, IDX_ACTUAL, 32'h1, rd, er);
    chk(er, 1'b1, "ro write");
    acc(1'b0, 16'h2FFF, 32'h0, rd, er);
    chk(er, 1'b1, "unmapped");
    acc(1'b1, IDX_CONTROL, 32'h0010, rd, er);
    acc(1'b0, IDX_CONTROL, 32'h0, rd, er);
    chk(rd, 32'h0010, "control");
  endtask : s_regs
  task automatic s_rx;
    int p0, a0;
    p0 = nPos;
    a0 = nAb;
    m.send(16'h0014, 32'h0000_0200, 7'h02);
    tick(3);
    chk(cmdControl, 16'h0010, "foreign frame");
    m.send(16'h0010, 32'h0000_0300, 7'h01);
    tick(3);
    chk(cmdTarget, 32'h0000_0300, "target");
    chk(nPos - p0, 0, "start w/o transfer");
    m.send(16'h0014, 32'h0000_0400, 7'h01);
    tick(3);
    chk(cmdControl, 16'h0014, "control");
    chk(nPos - p0, 1, "start");
    m.send(16'h0000, 32'h0000_0400, 7'h01);
    tick(3);
    chk(nAb - a0, 1, "abort");
    frame(16'h0020, 16'h0020);
  endtask : s_rx
  task automatic s_tx;
    m.stall = 3;
    currentSpeed = 16'h0123;
    actualPosition = 32'h0000_5678;
    mcp(14'h0100);
    frame(16'h0400, 16'h0400);
    chk(m.lastData[63:16], 48'h0000_5678_0123, "layout");
    m.stall = 0;
  endtask : s_tx
  task automatic s_keys;
    logic [15:0] mv [5] = '{16'h4651, 16'h4650, 16'h752F, 16'h7530, 16'h7530};
    logic [7:0] tc [5] = '{8'h00, 8'h00, 8'h51, 8'h4B, 8'h4A};
    logic [7:0] ex [5] = '{8'h10, 8'h00, 8'hD0, 8'hC0, 8'h00};
    logic [31:0] rd;
    logic er;
    jogRevKeyPin = 1'b1;
    frame(16'h000C, 16'h0004);
    acc(1'b0, IDX_STATUS, 32'h0, rd, er);
    chk(rd[3:2], 2'b01, "key read");
    jogRevKeyPin = 1'b0;
    jogFwdKeyPin = 1'b1;
    frame(16'h000C, 16'h0008);
    jogFwdKeyPin = 1'b0;
    for (int i = 0; i < 5; i++) begin
      motorMillivolt = mv[i];
      temperatureC = tc[i];
      mc[0] = ex[i][6];
      frame(16'h00D0, {8'h00, ex[i]});
    end
  endtask : s_keys
  task automatic s_err;
    int p0, r0;
    p0 = nPos;
    r0 = nRef;
    mcp(14'h0080);
    frame(16'h0200, 16'h0200);
    m.send(16'h0014, 32'h0000_0500, 7'h01);
    tick(3);
    chk(nPos - p0, 0, "start while faulted");
    m.send(16'h0090, 32'h0000_0500, 7'h01);
    tick(3);
    chk(nRef - r0, 1, "reference loop");
    mcp(14'h0018);
    frame(16'h0600, 16'h0000);
  endtask : s_err
  initial begin
    tick(8);
    rst = 1'b0;
    tick(3);
    s_regs();
    s_rx();
    s_tx();
    s_keys();
    s_err();
    stop_test();
  end
endmodule : testbench
